// ### core/wsc_pkg.sv
// Shared constants, types and reset values of the watchdog, sleep and configuration unit
package wsc_pkg;
	// Clock and time bases
	localparam int CLK_PERIOD_NS   = 10;
	localparam int RC_PERIOD_NS    = 1000;
	localparam int RC_DIV_CYCLES   = RC_PERIOD_NS / CLK_PERIOD_NS;
	localparam int WDT_TIMEOUT_MS  = 12;
	localparam int WDT_BASE_TICKS  = (WDT_TIMEOUT_MS * 1000000) / RC_PERIOD_NS;
	localparam int TMR_OVF_TOSC    = 65536;
	localparam int OST_TOSC        = 1024;
	localparam int POWER_UP_TIMER_POSTSCALE  = 8;
	localparam int CNT_W           = 17;
	localparam int PS_W            = 9;
	localparam int RC_DIV_W        = 7;
	localparam int OST_W           = 11;
	localparam logic [RC_DIV_W-1:0] RC_DIV_LAST = RC_DIV_W'(RC_DIV_CYCLES - 1);
	localparam logic [OST_W-1:0]    OST_LAST    = OST_W'(OST_TOSC - 1);
	// Postscale field codes and their last postscaler counts
	localparam logic [1:0]      WPS_TIMER = 2'h0;
	localparam logic [1:0]      WPS_64    = 2'h1;
	localparam logic [1:0]      WPS_256   = 2'h2;
	localparam logic [1:0]      WPS_1     = 2'h3;
	localparam logic [PS_W-1:0] PS_LAST_1    = 9'h000;
	localparam logic [PS_W-1:0] PS_LAST_64   = 9'h03F;
	localparam logic [PS_W-1:0] PS_LAST_256  = 9'h0FF;
	localparam logic [PS_W-1:0] PS_LAST_POWER_UP_TIMER = PS_W'(POWER_UP_TIMER_POSTSCALE - 1);
	// Oscillator select codes
	localparam logic [1:0] OSC_LF = 2'h0;
	localparam logic [1:0] OSC_RC = 2'h1;
	localparam logic [1:0] OSC_XT = 2'h2;
	localparam logic [1:0] OSC_EC = 2'h3;
	// Processor modes that map the configuration window into program memory
	localparam logic [2:0] PM_MICROCTRL = 3'h6;
	localparam logic [2:0] PM_CODE_PROT = 3'h0;
	// Configuration word layout
	localparam logic [11:0] CFG_PAGE      = 12'hFE0;
	localparam logic [15:0] CFG_RESET     = 16'hFFFF;
	localparam int          CFG_FOSC_LSB  = 0;
	localparam int          CFG_WPS_LSB   = 2;
	localparam int          CFG_PM0_BIT   = 4;
	localparam int          CFG_PM1_BIT   = 6;
	localparam int          CFG_BROWNOUT_DETECT_ENABLE_BIT = 14;
	localparam int          CFG_PM2_BIT   = 15;
	localparam logic [7:0]  TBL_HIGH_FILL = 8'hFF;
	// Register indices; byte address is four times the index
	localparam logic [5:0] REG_IDX_CFG    = 6'h00;
	localparam logic [5:0] REG_IDX_WSTAT  = 6'h01;
	localparam logic [5:0] REG_IDX_STATUS = 6'h06;
	localparam int ST_STACK_AVAILABLE  = 5;
	localparam int ST_GLOBAL_INT_DISABLE = 4;
	localparam int ST_TO     = 3;
	localparam int ST_PD     = 2;
	localparam logic GLOBAL_INT_DISABLE_RESET = 1'b1;
	localparam int WAKE_SRC_N = 8;

	typedef enum logic [1:0] {PWR_RUN, PWR_SLEEP, PWR_OST, PWR_POWER_UP_TIMER} wsc_pwr_e;

	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic [PS_W-1:0]  ps;
		logic             ovf;
	} wsc_cnt_s;

	typedef struct packed {
		logic                mclr_s1;
		logic                mclr_s2;
		logic [15:0]         cfg;
		logic [RC_DIV_W-1:0] rc_div;
		wsc_pwr_e            state;
		logic [OST_W-1:0]    ost_cnt;
		logic                wake_int;
		logic                to_n;
		logic                pd_n;
		logic                global_int_disable;
		logic                wdt_rst;
		logic                resume;
		logic                vector_after;
		logic [7:0]          tbl_lo;
		logic [7:0]          tbl_hi;
		logic                tbl_hit;
		logic [31:0]         prdata;
		logic                pslverr;
	} wsc_top_s;

	localparam wsc_top_s TOP_RESET = '{cfg: CFG_RESET, to_n: 1'b1, pd_n: 1'b1,
		global_int_disable: GLOBAL_INT_DISABLE_RESET, state: PWR_RUN, default: '0};
endpackage : wsc_pkg

// ### core/wsc_watchdog_sleep_config.sv
// Configuration fuses, watchdog timer and power-down controller with APB registers
// What this block does
// - Eight configuration fuses; programmed reads 0, unprogrammed reads 1.
// - A table write to a configuration address programs that bit, data ignored.
// - Reads of FE00h-FE07h give low config byte; high latch reads FFh.
// - Reads of FE08h-FE0Fh give high config byte; high latch reads FFh.
// - Window mapped only in microcontroller modes; programmer always reaches it.
// - Two-bit oscillator field picks low-power, crystal, external or RC clock.
// - Watchdog counts on its own free-running RC tick, also during sleep.
// - Enabled watchdog timeout in normal operation resets the device.
// - Postscale field 00 permanently disables watchdog reset.
// - Timeout 12 ms at postscale one, longer postscales up to about 3 s.
// - Counter cleared in reset, on sleep, on clear instruction, on interrupt wake.
// - Counting starts on the first edge after leaving reset.
// - Watchdog timeout clears the active-low timeout flag.
// - Counter and postscaler serve as power-up timer when that delay is invoked.
// - Plain timer mode: device clock, 65536 periods, flag only, stops in sleep.
// - Sleep clears watchdog, clears power-down flag, sets timeout flag, stops oscillator.
// - Only the listed interrupt sources may wake the device from sleep.
// - Reset-type wake resets the device; interrupt wake resumes execution.
// - Wake needs source enable, ignores global disable; vectoring follows global disable.
// - Pending enabled interrupt at sleep wakes at once; timeout set, power-down cleared.
// - Crystal modes hold the device 1024 oscillator periods on wake.
`timescale 1ns/1ns
module wsc_watchdog_sleep_config
	import wsc_pkg::*;
#(
	parameter int WDT_BASE_TICKS_P = WDT_BASE_TICKS,
	parameter int TMR_OVF_CYCLES_P = TMR_OVF_TOSC
)(
	// Clock and reset
	input  wire logic                  sys_clk_in,
	input  wire logic                  arst_n_in,
	// APB slave
	input  wire logic                  psel_in,
	input  wire logic                  penable_in,
	input  wire logic                  pwrite_in,
	input  wire logic [7:0]            paddr_in,
	input  wire logic [31:0]           pwdata_in,
	output logic [31:0]                prdata_out,
	output logic                       pready_out,
	output logic                       pslverr_out,
	// Processor core instructions
	input  wire logic                  sleep_instr_in,
	input  wire logic                  watchdog_clear_instr_in,
	input  wire logic                  table_read_instr_in,
	input  wire logic                  table_write_instr_in,
	input  wire logic [15:0]           table_addr_in,
	input  wire logic                  prog_access_in,
	input  wire logic                  stack_available_in,
	output logic [7:0]                 table_latch_low_out,
	output logic [7:0]                 table_latch_high_out,
	output logic                       table_cfg_hit_out,
	// Wake sources: int pin, port change, timer clock, capture, ssp tx, ssp rx, adc, slave
	input  wire logic [WAKE_SRC_N-1:0] wake_flag_in,
	input  wire logic [WAKE_SRC_N-1:0] wake_enable_in,
	// Reset and power control
	input  wire logic                  master_clear_n_in,
	input  wire logic                  power_up_timer_invoke_in,
	output logic                       core_reset_out,
	output logic                       core_hold_out,
	output logic                       wdt_reset_out,
	output logic                       osc_drive_out,
	output logic                       sleeping_out,
	output logic                       resume_out,
	output logic                       vector_after_out,
	output logic                       global_int_disable_out,
	output logic [1:0]                 osc_select_field_out,
	output logic                       brownout_detect_enable_out
);
	localparam logic [CNT_W-1:0] WDT_LAST = CNT_W'(WDT_BASE_TICKS_P - 1);
	localparam logic [CNT_W-1:0] TMR_LAST = CNT_W'(TMR_OVF_CYCLES_P - 1);

	// One-hot mask of the fuse behind a window address, zero for unused addresses
	function automatic logic [15:0] cfg_bit_mask(input logic [3:0] a);
		logic [15:0] m;
		m = 16'h0000;
		unique case (a)
			4'h0: m[CFG_FOSC_LSB] = 1'b1;
			4'h1: m[CFG_FOSC_LSB+1] = 1'b1;
			4'h2: m[CFG_WPS_LSB] = 1'b1;
			4'h3: m[CFG_WPS_LSB+1] = 1'b1;
			4'h4: m[CFG_PM0_BIT] = 1'b1;
			4'h6: m[CFG_PM1_BIT] = 1'b1;
			4'hE: m[CFG_BROWNOUT_DETECT_ENABLE_BIT] = 1'b1;
			4'hF: m[CFG_PM2_BIT] = 1'b1;
			default: m = 16'h0000;
		endcase
		return m;
	endfunction : cfg_bit_mask

	wsc_top_s          r_reg;
	wsc_top_s          r_next;
	logic              wdt_clr;
	logic              cnt_ovf;
	logic              cnt_tick;
	logic [CNT_W-1:0]  base_last;
	logic [PS_W-1:0]   ps_last;
	logic [1:0]        wps;
	logic [1:0]        osc;
	logic [2:0]        pmode;
	logic              wdt_on;
	logic              timer_mode;
	logic              crystal;
	logic              rc_tick;
	logic              wake_pend;
	logic              cfg_hit;
	logic              in_reset;
	logic              apb_setup;
	logic              apb_wr;
	logic [5:0]        reg_idx;
	logic              reg_ok;

	assign wps        = r_reg.cfg[CFG_WPS_LSB +: 2];
	assign osc        = r_reg.cfg[CFG_FOSC_LSB +: 2];
	assign pmode      = {r_reg.cfg[CFG_PM2_BIT], r_reg.cfg[CFG_PM1_BIT], r_reg.cfg[CFG_PM0_BIT]};
	assign wdt_on     = (wps != WPS_TIMER);
	assign timer_mode = !wdt_on && (r_reg.state != PWR_POWER_UP_TIMER);
	assign crystal    = (osc == OSC_LF) || (osc == OSC_XT);
	assign rc_tick    = (r_reg.rc_div == RC_DIV_LAST);
	assign wake_pend  = |(wake_flag_in & wake_enable_in);
	assign in_reset   = !r_reg.mclr_s2;
	assign cfg_hit    = (table_addr_in[15:4] == CFG_PAGE) &&
		(prog_access_in || pmode == PM_MICROCTRL || pmode == PM_CODE_PROT);
	assign reg_idx    = paddr_in[7:2];
	assign reg_ok     = (paddr_in[1:0] == 2'h0) && (reg_idx == REG_IDX_CFG ||
		reg_idx == REG_IDX_WSTAT || reg_idx == REG_IDX_STATUS);
	assign apb_setup  = psel_in && !penable_in;
	assign apb_wr     = psel_in && penable_in && pwrite_in;

	// Timer mode runs on the device clock and so stands still while asleep
	assign cnt_tick = timer_mode ? (r_reg.state == PWR_RUN) : rc_tick;
	assign base_last = timer_mode ? TMR_LAST : WDT_LAST;

	always_comb begin
		if (r_reg.state == PWR_POWER_UP_TIMER) begin
			ps_last = PS_LAST_POWER_UP_TIMER;
		end else begin
			unique case (wps)
				WPS_64:  ps_last = PS_LAST_64;
				WPS_256: ps_last = PS_LAST_256;
				WPS_1:   ps_last = PS_LAST_1;
				WPS_TIMER: ps_last = PS_LAST_1;
			endcase
		end
	end

	wsc_wdt_counter u_counter (
		.sys_clk_in   (sys_clk_in),
		.arst_n_in    (arst_n_in),
		.clear_in     (wdt_clr),
		.tick_in      (cnt_tick),
		.base_last_in (base_last),
		.ps_last_in   (ps_last),
		.ovf_out      (cnt_ovf)
	);

	always_comb begin
		r_next = r_reg;
		r_next.mclr_s1 = master_clear_n_in;
		r_next.mclr_s2 = r_reg.mclr_s1;
		r_next.wdt_rst = 1'b0;
		r_next.resume = 1'b0;
		// A reset pulse in flight counts as the reset state for the counter
		wdt_clr = r_reg.wdt_rst;
		// RC tick divider never stops, not even in sleep
		r_next.rc_div = rc_tick ? '0 : r_reg.rc_div + 1'b1;

		if (table_read_instr_in && cfg_hit) begin
			r_next.tbl_hit = 1'b1;
			r_next.tbl_lo = table_addr_in[3] ? r_reg.cfg[15:8] : r_reg.cfg[7:0];
			r_next.tbl_hi = TBL_HIGH_FILL;
		end else if (table_read_instr_in) begin
			r_next.tbl_hit = 1'b0;
		end
		// Programming only ever clears a fuse; only the asynchronous reset sets it back
		if (table_write_instr_in && cfg_hit) begin
			r_next.cfg = r_reg.cfg & ~cfg_bit_mask(table_addr_in[3:0]);
		end

		if (apb_setup) begin
			r_next.pslverr = !reg_ok;
			r_next.prdata = 32'h0000_0000;
			if (reg_ok && reg_idx == REG_IDX_CFG) begin
				r_next.prdata[15:0] = r_reg.cfg;
			end else if (reg_ok && reg_idx == REG_IDX_WSTAT) begin
				r_next.prdata[3:0] = {wdt_on, r_reg.wake_int, r_reg.state};
			end else if (reg_ok) begin
				r_next.prdata[ST_STACK_AVAILABLE] = stack_available_in;
				r_next.prdata[ST_GLOBAL_INT_DISABLE] = r_reg.global_int_disable;
				r_next.prdata[ST_TO] = r_reg.to_n;
				r_next.prdata[ST_PD] = r_reg.pd_n;
			end
		end
		if (apb_wr && reg_ok && reg_idx == REG_IDX_STATUS) begin
			r_next.global_int_disable = pwdata_in[ST_GLOBAL_INT_DISABLE];
		end

		unique case (r_reg.state)
			PWR_RUN: begin
				if (watchdog_clear_instr_in) begin
					wdt_clr = 1'b1;
					r_next.to_n = 1'b1;
				end else if (sleep_instr_in) begin
					wdt_clr = 1'b1;
					r_next.pd_n = 1'b0;
					r_next.to_n = 1'b1;
					if (wake_pend) begin
						r_next.resume = 1'b1;
						r_next.vector_after = !r_reg.global_int_disable;
					end else begin
						r_next.state = PWR_SLEEP;
					end
				end else if (cnt_ovf) begin
					r_next.to_n = 1'b0;
					r_next.wdt_rst = wdt_on;
				end
			end
			PWR_SLEEP: begin
				if (cnt_ovf && wdt_on) begin
					r_next.to_n = 1'b0;
					r_next.wdt_rst = 1'b1;
					r_next.wake_int = 1'b0;
					r_next.state = crystal ? PWR_OST : PWR_RUN;
				end else if (wake_pend) begin
					wdt_clr = 1'b1;
					r_next.wake_int = 1'b1;
					r_next.state = crystal ? PWR_OST : PWR_RUN;
					r_next.resume = !crystal;
					r_next.vector_after = !r_reg.global_int_disable;
				end
			end
			PWR_OST: begin
				r_next.ost_cnt = r_reg.ost_cnt + 1'b1;
				if (r_reg.ost_cnt == OST_LAST) begin
					r_next.ost_cnt = '0;
					r_next.state = PWR_RUN;
					r_next.resume = r_reg.wake_int;
					r_next.vector_after = !r_reg.global_int_disable;
					r_next.wake_int = 1'b0;
				end
			end
			PWR_POWER_UP_TIMER: begin
				if (cnt_ovf) begin
					r_next.state = PWR_RUN;
				end
			end
		endcase

		// Held reset clears the counter; counting resumes at the first edge after
		if (in_reset) begin
			wdt_clr = 1'b1;
			r_next.state = PWR_RUN;
			r_next.wake_int = 1'b0;
			r_next.ost_cnt = '0;
		end else if (power_up_timer_invoke_in) begin
			wdt_clr = 1'b1;
			r_next.state = PWR_POWER_UP_TIMER;
		end
	end

	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			r_reg <= TOP_RESET;
		end else begin
			r_reg <= r_next;
		end
	end

	assign prdata_out = r_reg.prdata;
	assign pready_out = 1'b1;
	assign pslverr_out = r_reg.pslverr;
	assign table_latch_low_out = r_reg.tbl_lo;
	assign table_latch_high_out = r_reg.tbl_hi;
	assign table_cfg_hit_out = r_reg.tbl_hit;
	assign core_reset_out = in_reset || r_reg.wdt_rst || (r_reg.state == PWR_POWER_UP_TIMER);
	assign core_hold_out = (r_reg.state == PWR_OST);
	assign wdt_reset_out = r_reg.wdt_rst;
	// Pins keep their state; only the oscillator driver is turned off in sleep
	assign osc_drive_out = (r_reg.state != PWR_SLEEP);
	assign sleeping_out = (r_reg.state == PWR_SLEEP);
	assign resume_out = r_reg.resume;
	assign vector_after_out = r_reg.vector_after;
	assign global_int_disable_out = r_reg.global_int_disable;
	assign osc_select_field_out = osc;
	assign brownout_detect_enable_out = r_reg.cfg[CFG_BROWNOUT_DETECT_ENABLE_BIT];

	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!arst_n_in);

	property p_low_window;
		table_read_instr_in && cfg_hit && !table_addr_in[3] |=>
			table_latch_low_out == $past(r_reg.cfg[7:0]) && table_latch_high_out == 8'hFF;
	endproperty
	a_low_window: assert property (p_low_window) else $error("low window read wrong");

	property p_high_window;
		table_read_instr_in && cfg_hit && table_addr_in[3] |=>
			table_latch_low_out == $past(r_reg.cfg[15:8]) && table_cfg_hit_out;
	endproperty
	a_high_window: assert property (p_high_window) else $error("high window read wrong");

	property p_program;
		table_write_instr_in && cfg_hit && table_addr_in[3:0] == 4'h2 |=>
			!r_reg.cfg[CFG_WPS_LSB] && r_reg.cfg[7:3] == $past(r_reg.cfg[7:3]);
	endproperty
	a_program: assert property (p_program) else $error("fuse not programmed");

	property p_unmapped;
		table_read_instr_in && !prog_access_in && pmode != PM_MICROCTRL &&
			pmode != PM_CODE_PROT |=> !table_cfg_hit_out;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("window mapped in wrong mode");

	property p_sleep_entry;
		r_reg.state == PWR_RUN && sleep_instr_in && !watchdog_clear_instr_in && !wake_pend &&
			!in_reset && !power_up_timer_invoke_in |=> sleeping_out && !osc_drive_out &&
			r_reg.to_n && !r_reg.pd_n;
	endproperty
	a_sleep_entry: assert property (p_sleep_entry) else $error("sleep entry wrong");

	property p_immediate_wake;
		r_reg.state == PWR_RUN && sleep_instr_in && !watchdog_clear_instr_in && wake_pend &&
			!in_reset && !power_up_timer_invoke_in |=> resume_out && !sleeping_out && !r_reg.pd_n;
	endproperty
	a_immediate_wake: assert property (p_immediate_wake) else $error("no immediate wake");

	property p_wdt_reset;
		r_reg.state == PWR_RUN && cnt_ovf && wdt_on && !watchdog_clear_instr_in &&
			!sleep_instr_in && !in_reset && !power_up_timer_invoke_in |=>
			wdt_reset_out && core_reset_out && !r_reg.to_n ##1 !wdt_reset_out;
	endproperty
	a_wdt_reset: assert property (p_wdt_reset) else $error("watchdog reset missing");

	property p_timer_mode;
		r_reg.state == PWR_RUN && cnt_ovf && !wdt_on && !watchdog_clear_instr_in &&
			!sleep_instr_in && !in_reset && !power_up_timer_invoke_in |=> !wdt_reset_out && !r_reg.to_n;
	endproperty
	a_timer_mode: assert property (p_timer_mode) else $error("timer overflow wrong");

	property p_disabled;
		!wdt_on |=> !wdt_reset_out;
	endproperty
	a_disabled: assert property (p_disabled) else $error("disabled watchdog reset");

	// Helper: length of the current start-up hold, so its end is bounded without long ranges
	logic [OST_W:0] hold_run;

	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			hold_run <= '0;
		end else begin
			hold_run <= core_hold_out ? hold_run + 1'b1 : '0;
		end
	end

	property p_ost_hold;
		r_reg.state == PWR_SLEEP && wake_pend && !(cnt_ovf && wdt_on) && crystal &&
			!in_reset && !power_up_timer_invoke_in |=> core_hold_out [*8];
	endproperty
	a_ost_hold: assert property (p_ost_hold) else $error("start-up hold wrong");

	property p_ost_len;
		hold_run <= (OST_W+1)'(OST_TOSC);
	endproperty
	a_ost_len: assert property (p_ost_len) else $error("start-up hold too long");

	property p_wake_vector;
		resume_out |-> vector_after_out == !$past(r_reg.global_int_disable);
	endproperty
	a_wake_vector: assert property (p_wake_vector) else $error("vector choice wrong");

	c_sleep_wake: cover property (sleeping_out ##[1:50] resume_out);
	c_wdt_reset: cover property (wdt_reset_out);
	c_immediate: cover property (sleep_instr_in && wake_pend && r_reg.state == PWR_RUN);
	c_ost: cover property ($fell(core_hold_out));
endmodule : wsc_watchdog_sleep_config

// ### core/wsc_wdt_counter.sv
// Watchdog counter with postscaler, shared with the power-up timer
`timescale 1ns/1ns
module wsc_wdt_counter
	import wsc_pkg::*;
(
	// Clock and reset
	input  wire logic             sys_clk_in,
	input  wire logic             arst_n_in,
	// Control
	input  wire logic             clear_in,
	input  wire logic             tick_in,
	input  wire logic [CNT_W-1:0] base_last_in,
	input  wire logic [PS_W-1:0]  ps_last_in,
	// Result
	output logic                  ovf_out
);
	wsc_cnt_s r_reg;
	wsc_cnt_s r_next;

	always_comb begin
		r_next = r_reg;
		r_next.ovf = 1'b0;
		if (clear_in) begin
			r_next.cnt = '0;
			r_next.ps = '0;
		end else if (tick_in) begin
			if (r_reg.cnt >= base_last_in) begin
				r_next.cnt = '0;
				if (r_reg.ps >= ps_last_in) begin
					r_next.ps = '0;
					r_next.ovf = 1'b1;
				end else begin
					r_next.ps = r_reg.ps + 1'b1;
				end
			end else begin
				r_next.cnt = r_reg.cnt + 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign ovf_out = r_reg.ovf;
endmodule : wsc_wdt_counter

// ### verification/tb_top.sv
// Self-checking bench for the watchdog, sleep and configuration unit
`timescale 1ns/1ns
module tb_top;
	import wsc_pkg::*;
	logic        clk, rst_n, psel, pen, pwr, prdy, perr, tr, tw, pacc, stk, mcn, pwi;
	logic        clr_en, slp_req, sl, cl, hit, crst, hold, wrst, osd, slp, res, vec, e;
	logic [7:0]  pa, tll, tlh, wf, we;
	logic [15:0] ta;
	logic [1:0]  osc;
	logic [31:0] pwd, prd, rd;
	int          fail_count, checked, mcfg, n;
	int          prog[6] = '{0, 2, 3, 4, 6, 15};
	wsc_watchdog_sleep_config #(.WDT_BASE_TICKS_P(4), .TMR_OVF_CYCLES_P(64)) u_wsc_watchdog_sleep_config (
		.sys_clk_in(clk), .arst_n_in(rst_n), .psel_in(psel), .penable_in(pen),
		.pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd), .prdata_out(prd),
		.pready_out(prdy), .pslverr_out(perr), .sleep_instr_in(sl),
		.watchdog_clear_instr_in(cl), .table_read_instr_in(tr), .table_write_instr_in(tw),
		.table_addr_in(ta), .prog_access_in(pacc), .stack_available_in(stk),
		.table_latch_low_out(tll), .table_latch_high_out(tlh), .table_cfg_hit_out(hit),
		.wake_flag_in(wf), .wake_enable_in(we), .master_clear_n_in(mcn),
		.power_up_timer_invoke_in(pwi), .core_reset_out(crst), .core_hold_out(hold),
		.wdt_reset_out(wrst), .osc_drive_out(osd), .sleeping_out(slp), .resume_out(res),
		.vector_after_out(vec), .global_int_disable_out(), .osc_select_field_out(osc),
		.brownout_detect_enable_out());
	wsc_core_model u_wsc_core_model (.clk_in(clk), .rst_n_in(rst_n), .clr_en_in(clr_en),
		.slp_req_in(slp_req), .halt_in(slp | crst | hold), .sleep_out(sl), .clear_out(cl));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic finish_test;
		$display("compares %0d, mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : finish_test
	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		checked++;
		if (s !== x) begin
			fail_count++;
			$display("wrong value at %0t: got %h, expected %h", $time, s, x);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk) {psel, pen, pwr, pa, pwd} <= {2'b10, w, a, d};
		@(posedge clk) pen <= 1'b1;
		do @(posedge clk); while (prdy !== 1'b1);
		rd = prd;
		e = perr;
		{psel, pen} <= 2'b00;
	endtask : apb
	task automatic tbl(input logic w, input logic [15:0] a);
		@(posedge clk) {tr, tw, ta} <= {!w, w, a};
		@(posedge clk) {tr, tw} <= 2'b00;
		@(negedge clk);
		if (w && a[3:0] inside {0, 1, 2, 3, 4, 6, 14, 15}) mcfg &= ~(1 << a[3:0]);
	endtask : tbl
	task automatic rdc(input logic [15:0] a);
		tbl(1'b0, a);
		chk({tlh, tll}, {8'hFF, a[3] ? mcfg[15:8] : mcfg[7:0]});
	endtask : rdc
	task automatic wt(input logic k, input int lim);
		n = 0;
		@(negedge clk);
		while ((k ? wrst : res) !== 1'b1 && n < lim) begin
			@(negedge clk);
			n++;
		end
	endtask : wt
	task automatic slp_go;
		@(posedge clk) slp_req <= 1'b1;
		@(posedge clk) slp_req <= 1'b0;
		repeat (3) @(negedge clk);
	endtask : slp_go
	task automatic pulse_clear;
		@(posedge clk) clr_en <= 1'b1;
		@(posedge clk) clr_en <= 1'b0;
		repeat (3) @(posedge clk);
	endtask : pulse_clear
	task automatic do_reset;
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		mcfg = 16'hFFFF;
		repeat (3) @(posedge clk);
	endtask : do_reset
	initial begin
		{psel, pen, pwr, pa, pwd, tr, tw, ta, pacc, pwi, clr_en, slp_req, wf, we} = '0;
		{rst_n, mcn, fail_count, checked} = '0;
		mcn = 1'b1;
		n = $urandom(32'h968f9d8b);
		stk = $urandom;
		do_reset;
		clr_en <= 1'b1;
		apb(0, 8'h18, 0);
		chk({rd, e}, {26'h0, stk, 5'b11100, 1'b0});
		apb(0, 8'h00, 0);
		chk(rd, mcfg);
		apb(1, 8'h08, $urandom);
		chk(e, 1'b1);
		apb(0, 8'h19, 0);
		chk(e, 1'b1);
		tbl(0, 16'hFE03);
		chk(hit, 1'b0);
		pacc <= 1'b1;
		rdc(16'hFE0C);
		tbl(1, 16'hFE01);
		tbl(1, 16'hFE05);
		rdc(16'hFE07);
		chk(osc, 2'h1);
		for (int i = 0; i < 8; i++) begin
			apb(1, 8'h18, 32'(i[0]) << 4);
			@(posedge clk) {wf, we} <= {8'($urandom), 8'h00};
			slp_go;
			chk({slp, osd}, 2'b10);
			apb(0, 8'h18, 0);
			chk(rd[3:2], 2'b10);
			@(posedge clk) {wf, we} <= {8'h1 << i, 8'h1 << i};
			wt(0, 20);
			chk({n < 20, vec}, {1'b1, !i[0]});
			we <= 8'h00;
		end
		slp_go;
		@(posedge clk) {wf, we} <= 16'h0101;
		slp_go;
		chk(slp, 1'b0);
		apb(0, 8'h18, 0);
		chk(rd[3:2], 2'b10);
		we <= 8'h00;
		clr_en <= 1'b1;
		wt(1, 900);
		chk(n, 900);
		pulse_clear;
		wt(1, 700);
		chk(n >= 290 && n <= 510, 1'b1);
		repeat (20) @(posedge clk);
		apb(0, 8'h18, 0);
		chk(rd[3], 1'b0);
		pulse_clear;
		apb(0, 8'h18, 0);
		chk(rd[3], 1'b1);
		do_reset;
		foreach (prog[i]) tbl(1, 16'hFE00 + 16'(prog[i]));
		pacc <= 1'b0;
		rdc(16'hFE0A);
		chk({hit, osc}, 3'b110);
		apb(0, 8'h00, 0);
		chk(rd, mcfg);
		wt(1, 300);
		chk(n, 300);
		apb(0, 8'h18, 0);
		chk(rd[3], 1'b0);
		pulse_clear;
		apb(0, 8'h18, 0);
		chk(rd[3], 1'b1);
		slp_go;
		@(posedge clk) {wf, we} <= 16'h0808;
		repeat (3) @(negedge clk);
		chk(hold, 1'b1);
		wt(0, 1200);
		chk(n >= 1015 && n <= 1030, 1'b1);
		finish_test;
	end
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		finish_test;
	end
endmodule : tb_top

// ### verification/wsc_core_model.sv
// Core model issuing clear-watchdog and sleep instructions
`timescale 1ns/1ns
module wsc_core_model (
	// Clock and reset
	input  wire logic clk_in,
	input  wire logic rst_n_in,
	// Requests and core state
	input  wire logic clr_en_in,
	input  wire logic slp_req_in,
	input  wire logic halt_in,
	// Instructions
	output logic      sleep_out,
	output logic      clear_out
);
	int n;
	// A stopped core issues nothing; clear fires on enable, then every 100 cycles
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			n <= 0;
			sleep_out <= 1'b0;
			clear_out <= 1'b0;
		end else begin
			sleep_out <= slp_req_in && !halt_in && !sleep_out;
			clear_out <= clr_en_in && !halt_in && n == 0;
			n <= clr_en_in ? (n + 1) % 100 : 0;
		end
	end
endmodule : wsc_core_model
